// ---- logic/grmb_mailbox.sv ----
// Module: host mailbox for general register access and unsolicited reports
//
// Functional notes
// - Control bit 5 set means read, clear means write.
// - Control byte goes to port 10b, data to 11b; data starts work.
// - Device echoes the received control byte, with bit 7 cleared, into the mailbox.
// - Write answers 00h ok or 01h error; read answers register contents.
// - With the answer placed, the interrupt output goes low.
// - Every general register command is answered, once any unread answer has been read.
// - With no answer ready, both mailbox bytes read zero.
// - Host reads control then data; the data read releases the interrupt.
// - Returned bit 7 only for unsolicited; bit 5 and address echo.
// - Enabled detect changes post an unsolicited report of that register.
// - Unsolicited reports clear word/byte; direction repeats the last command.
// - Reading the data byte clears the interrupt; none is raised before.
// - Enable registers gate detect changes bit by bit.
// - Error measure reads as low byte 11h and high byte 12h.
`default_nettype none

module grmb_mailbox #(
	// Arbitrary revision code
	parameter logic [7:0] REVISION = 8'h5a
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire grmb_pkg::grmb_host_req_s host_req,
	output logic [7:0] host_rdata,
	output logic host_irq_n,
	input wire grmb_pkg::grmb_status_s pump_status,
	output grmb_pkg::grmb_ctrl_t pump_ctrl
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		grmb_pkg::grmb_state_e state;
		logic [7:0] ctl_in;
		logic [7:0] cmd_ctl;
		logic [7:0] cmd_data;
		logic cmd_pending;
		logic last_dir;
		grmb_pkg::grmb_mbx_s mbx;
		logic mbx_valid;
		logic irq_n;
		logic [7:0] rdata;
	} grmb_top_s;

	grmb_top_s s;
	grmb_top_s next_s;

	logic rf_wr;
	logic [7:0] rf_rd;
	logic rf_writable;
	logic rf_readable;
	logic cmd_bad;
	logic cmd_is_read;
	logic [2:0] det_pend;
	logic [2:0] det_clear;
	logic host_ctl_wr;
	logic host_data_wr;
	logic host_ctl_rd;
	logic host_data_rd;

	// ****************************************
	// Host port decode
	// ****************************************
	assign host_ctl_wr = host_req.wr && host_req.mailbox_port_select == grmb_pkg::PORT_CTL;
	assign host_data_wr = host_req.wr && host_req.mailbox_port_select == grmb_pkg::PORT_DATA;
	assign host_ctl_rd = host_req.rd && host_req.mailbox_port_select == grmb_pkg::PORT_CTL;
	assign host_data_rd = host_req.rd && host_req.mailbox_port_select == grmb_pkg::PORT_DATA;

	// Malformed commands and the configuration slot are refused: error answer on write, zero on read
	assign cmd_bad = s.cmd_ctl[grmb_pkg::CTL_UNSOL_BIT]
		| s.cmd_ctl[grmb_pkg::CTL_WB_BIT]
		| (s.cmd_ctl[4:0] == grmb_pkg::ADDR_CFG_SLOT);
	assign cmd_is_read = s.cmd_ctl[grmb_pkg::CTL_DIR_BIT];

	// ****************************************
	// Register file and detectors
	// ****************************************
	grmb_regfile #(
		.REVISION(REVISION)
	) u_regfile (
		.ref_clk(ref_clk),
		.srst(srst),
		.wr_en(rf_wr),
		.addr(s.cmd_ctl[4:0]),
		.wdata(s.cmd_data),
		.status(pump_status),
		.rd_data(rf_rd),
		.writable(rf_writable),
		.readable(rf_readable),
		.ctrl(pump_ctrl)
	);

	grmb_change_detect u_det_one (
		.ref_clk(ref_clk),
		.srst(srst),
		.status(pump_status.detect_one_status),
		.enable(pump_ctrl[grmb_pkg::IDX_DETECT_ONE_ENABLE]),
		.clear(det_clear[0]),
		.pending(det_pend[0])
	);

	grmb_change_detect u_det_two (
		.ref_clk(ref_clk),
		.srst(srst),
		.status(pump_status.detect_two_status),
		.enable(pump_ctrl[grmb_pkg::IDX_DETECT_TWO_ENABLE]),
		.clear(det_clear[1]),
		.pending(det_pend[1])
	);

	grmb_change_detect u_det_tone (
		.ref_clk(ref_clk),
		.srst(srst),
		.status(pump_status.precise_tone_detect_status),
		.enable(pump_ctrl[grmb_pkg::IDX_PRECISE_TONE_DETECT_ENABLE]),
		.clear(det_clear[2]),
		.pending(det_pend[2])
	);

	// ****************************************
	// Mailbox sequencing
	// ****************************************
	always_comb begin
		next_s = s;
		rf_wr = 1'b0;
		det_clear = 3'h0;

		// Host reads; an empty mailbox reads as zero
		if (host_ctl_rd) begin
			next_s.rdata = s.mbx_valid ? s.mbx.ctl : grmb_pkg::NULL_BYTE;
		end else if (host_data_rd) begin
			next_s.rdata = s.mbx_valid ? s.mbx.data : grmb_pkg::NULL_BYTE;
			if (s.mbx_valid) begin
				next_s.mbx_valid = 1'b0;
				next_s.irq_n = 1'b1;
			end
		end else if (host_req.rd) begin
			next_s.rdata = grmb_pkg::NULL_BYTE;
		end

		case (s.state)
			grmb_pkg::ST_IDLE: begin
				if (s.cmd_pending) begin
					next_s.state = grmb_pkg::ST_EXEC;
				end else if (det_pend != 3'h0) begin
					// Unsolicited report: bit 7 set, word/byte clear
					next_s.mbx.ctl[grmb_pkg::CTL_UNSOL_BIT] = 1'b1;
					next_s.mbx.ctl[grmb_pkg::CTL_WB_BIT] = 1'b0;
					next_s.mbx.ctl[grmb_pkg::CTL_DIR_BIT] = s.last_dir;
					if (det_pend[0]) begin
						next_s.mbx.ctl[4:0] = grmb_pkg::ADDR_DETECT_ONE_STATUS;
						next_s.mbx.data = pump_status.detect_one_status;
						det_clear[0] = 1'b1;
					end else if (det_pend[1]) begin
						next_s.mbx.ctl[4:0] = grmb_pkg::ADDR_DETECT_TWO_STATUS;
						next_s.mbx.data = pump_status.detect_two_status;
						det_clear[1] = 1'b1;
					end else begin
						next_s.mbx.ctl[4:0] = grmb_pkg::ADDR_PRECISE_TONE_DETECT_STATUS;
						next_s.mbx.data = pump_status.precise_tone_detect_status;
						det_clear[2] = 1'b1;
					end
					next_s.mbx_valid = 1'b1;
					next_s.irq_n = 1'b0;
					next_s.state = grmb_pkg::ST_WAIT;
				end
			end
			grmb_pkg::ST_EXEC: begin
				// Echo with bit 7 clear: this answers the last command
				next_s.mbx.ctl = {1'b0, s.cmd_ctl[6:0]};
				next_s.last_dir = cmd_is_read;
				if (cmd_is_read) begin
					next_s.mbx.data = (!cmd_bad && rf_readable) ? rf_rd : grmb_pkg::NULL_BYTE;
				end else if (!cmd_bad && rf_writable) begin
					rf_wr = 1'b1;
					next_s.mbx.data = grmb_pkg::RESP_OK;
				end else begin
					next_s.mbx.data = grmb_pkg::RESP_ERR;
				end
				next_s.cmd_pending = 1'b0;
				next_s.mbx_valid = 1'b1;
				next_s.irq_n = 1'b0;
				next_s.state = grmb_pkg::ST_WAIT;
			end
			grmb_pkg::ST_WAIT: begin
				// Nothing new is posted until the answer is read
				if (!next_s.mbx_valid) begin
					next_s.state = grmb_pkg::ST_IDLE;
				end
			end
			default: begin
				next_s.state = grmb_pkg::ST_IDLE;
			end
		endcase

		// Host writes last so a fresh command is never lost
		if (host_ctl_wr) begin
			next_s.ctl_in = host_req.wdata;
		end
		if (host_data_wr) begin
			next_s.cmd_ctl = s.ctl_in;
			next_s.cmd_data = host_req.wdata;
			next_s.cmd_pending = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s <= '0;
			s.state <= grmb_pkg::ST_IDLE;
			s.irq_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign host_rdata = s.rdata;
	assign host_irq_n = s.irq_n;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	logic [7:0] echo_exp;
	logic exec_write_ok;
	logic exec_write_err;
	logic exec_read_ok;
	logic exec_read_bad;
	logic unsol_go;
	assign echo_exp = {1'b0, s.cmd_ctl[6:0]};
	assign exec_write_ok = s.state == grmb_pkg::ST_EXEC && !cmd_is_read && !cmd_bad
		&& rf_writable;
	assign exec_write_err = s.state == grmb_pkg::ST_EXEC && !cmd_is_read
		&& (cmd_bad || !rf_writable);
	assign exec_read_ok = s.state == grmb_pkg::ST_EXEC && cmd_is_read && !cmd_bad
		&& rf_readable;
	assign exec_read_bad = s.state == grmb_pkg::ST_EXEC && cmd_is_read
		&& (cmd_bad || !rf_readable);
	// Detect one beats detect two, which beats the precise tone detector
	assign unsol_go = s.state == grmb_pkg::ST_IDLE && !s.cmd_pending && det_pend != 3'h0;

	sequence seq_cmd_taken;
		host_data_wr && s.state == grmb_pkg::ST_IDLE && !s.cmd_pending && det_pend == 3'h0;
	endsequence

	sequence seq_exec_step;
		s.state == grmb_pkg::ST_EXEC;
	endsequence

	a_cmd_answer_irq: assert property (
		seq_cmd_taken |-> ##2 seq_exec_step ##1 (!host_irq_n && s.mbx_valid))
		else $error("Command not answered with interrupt three cycles after data write");

	a_echo_ctl: assert property (
		seq_exec_step |=> s.mbx.ctl == $past(echo_exp))
		else $error("Answer control byte is not the echo of the command");

	a_write_ok_code: assert property (
		exec_write_ok |=> s.mbx.data == grmb_pkg::RESP_OK)
		else $error("Accepted write did not answer with the ok code");

	a_write_err_code: assert property (
		exec_write_err |=> s.mbx.data == grmb_pkg::RESP_ERR)
		else $error("Refused write did not answer with the error code");

	a_read_contents: assert property (
		exec_read_ok |=> s.mbx.data == $past(rf_rd))
		else $error("Read answer does not carry the register contents");

	a_data_read_release: assert property (
		(s.mbx_valid && host_data_rd) |=> host_irq_n && !s.mbx_valid
			&& host_rdata == $past(s.mbx.data))
		else $error("Data byte read did not release the interrupt");

	a_polled_zero: assert property (
		(host_req.rd && !s.mbx_valid) |=> host_rdata == grmb_pkg::NULL_BYTE)
		else $error("Empty mailbox did not read as zero");

	a_unsol_post: assert property (
		(s.state == grmb_pkg::ST_IDLE && !s.cmd_pending && det_pend != 3'h0)
			|=> s.mbx.ctl[7] && !s.mbx.ctl[6] && !host_irq_n
			&& s.mbx.ctl[5] == $past(s.last_dir))
		else $error("Unsolicited report posted with wrong control bits");

	a_hold_unread: assert property (
		(s.mbx_valid && !host_data_rd) |=> s.mbx_valid && $stable(s.mbx) && !host_irq_n)
		else $error("Unread answer was changed or released");

	a_ctl_alone_idle: assert property (
		(s.state == grmb_pkg::ST_IDLE && !s.cmd_pending && det_pend == 3'h0
			&& host_ctl_wr) |=> (s.state != grmb_pkg::ST_EXEC) [*2])
		else $error("Control byte alone started a command");

	a_bad_read_zero: assert property (
		exec_read_bad |=> s.mbx.data == grmb_pkg::NULL_BYTE)
		else $error("Refused read did not answer with a zero byte");

	a_irq_tracks_valid: assert property (
		host_irq_n == !s.mbx_valid)
		else $error("Interrupt level does not match the mailbox contents");

	a_ctl_read_keeps: assert property (
		(s.mbx_valid && host_ctl_rd) |=> s.mbx_valid && !host_irq_n
			&& host_rdata == $past(s.mbx.ctl))
		else $error("Control byte read changed the pending answer");

	a_rdata_hold: assert property (
		!host_req.rd |=> $stable(host_rdata))
		else $error("Read byte changed without a host read");

	a_unsol_first: assert property (
		(unsol_go && det_pend[0])
			|=> s.mbx.ctl[4:0] == grmb_pkg::ADDR_DETECT_ONE_STATUS
			&& s.mbx.data == $past(pump_status.detect_one_status))
		else $error("First detector report carries the wrong register");

	a_unsol_second: assert property (
		(unsol_go && det_pend[1:0] == 2'h2)
			|=> s.mbx.ctl[4:0] == grmb_pkg::ADDR_DETECT_TWO_STATUS
			&& s.mbx.data == $past(pump_status.detect_two_status))
		else $error("Second detector report carries the wrong register");

	a_unsol_tone: assert property (
		(unsol_go && det_pend[1:0] == 2'h0)
			|=> s.mbx.ctl[4:0] == grmb_pkg::ADDR_PRECISE_TONE_DETECT_STATUS
			&& s.mbx.data == $past(pump_status.precise_tone_detect_status))
		else $error("Tone detector report carries the wrong register");

	a_cmd_held: assert property (
		(s.mbx_valid && host_data_wr && !host_req.rd)
			|=> s.cmd_pending && s.state == grmb_pkg::ST_WAIT)
		else $error("Command under an unread answer was not held");

endmodule : grmb_mailbox

`default_nettype wire

// ---- logic/grmb_pkg.sv ----
// Package: constants and types shared by the general register mailbox
`default_nettype none

package grmb_pkg;

	// ****************************************
	// Mailbox port selects and control byte
	// ****************************************
	localparam logic [1:0] PORT_CTL = 2'h2;
	localparam logic [1:0] PORT_DATA = 2'h3;
	localparam int CTL_UNSOL_BIT = 7;
	localparam int CTL_WB_BIT = 6;
	localparam int CTL_DIR_BIT = 5;
	localparam logic [7:0] RESP_OK = 8'h00;
	localparam logic [7:0] RESP_ERR = 8'h01;
	localparam logic [7:0] NULL_BYTE = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ****************************************
	// General register addresses
	// ****************************************
	localparam logic [4:0] ADDR_CFG_SLOT = 5'h00;
	localparam logic [4:0] ADDR_HANDSHAKE_SELECT = 5'h01;
	localparam logic [4:0] ADDR_CONNECTION_RESULT = 5'h02;
	localparam logic [4:0] ADDR_TONE_DIAL_DIGIT = 5'h03;
	localparam logic [4:0] ADDR_TONE_DIGIT_DETECTED = 5'h04;
	localparam logic [4:0] ADDR_DATA_MODE_CONTROL = 5'h05;
	localparam logic [4:0] ADDR_TEST_CONTROL = 5'h06;
	localparam logic [4:0] ADDR_SILICON_REVISION = 5'h07;
	localparam logic [4:0] ADDR_DETECT_ONE_ENABLE = 5'h08;
	localparam logic [4:0] ADDR_DETECT_ONE_STATUS = 5'h09;
	localparam logic [4:0] ADDR_DETECT_TWO_ENABLE = 5'h0a;
	localparam logic [4:0] ADDR_DETECT_TWO_STATUS = 5'h0b;
	localparam logic [4:0] ADDR_TRANSMIT_CONTROL = 5'h0c;
	localparam logic [4:0] ADDR_GENERAL_CONTROL = 5'h0d;
	localparam logic [4:0] ADDR_FAX_HANDSHAKE_CONTROL = 5'h0e;
	localparam logic [4:0] ADDR_RESERVED_SLOT = 5'h0f;
	localparam logic [4:0] ADDR_OPERATING_MODE_CONTROL = 5'h10;
	localparam logic [4:0] ADDR_ERROR_MAGNITUDE_LOW = 5'h11;
	localparam logic [4:0] ADDR_ERROR_MAGNITUDE_HIGH = 5'h12;
	localparam logic [4:0] ADDR_CALL_PROGRESS_TX_CONTROL = 5'h14;
	localparam logic [4:0] ADDR_PRECISE_TONE_DETECT_ENABLE = 5'h18;
	localparam logic [4:0] ADDR_PRECISE_TONE_DETECT_STATUS = 5'h19;

	// Writable registers, index order of the control array
	localparam int RW_COUNT = 12;
	localparam logic [RW_COUNT-1:0][4:0] RW_ADDRS = {
		ADDR_PRECISE_TONE_DETECT_ENABLE, ADDR_CALL_PROGRESS_TX_CONTROL,
		ADDR_OPERATING_MODE_CONTROL, ADDR_FAX_HANDSHAKE_CONTROL,
		ADDR_GENERAL_CONTROL, ADDR_TRANSMIT_CONTROL, ADDR_DETECT_TWO_ENABLE,
		ADDR_DETECT_ONE_ENABLE, ADDR_TEST_CONTROL, ADDR_DATA_MODE_CONTROL,
		ADDR_TONE_DIAL_DIGIT, ADDR_HANDSHAKE_SELECT};
	localparam int IDX_DETECT_ONE_ENABLE = 4;
	localparam int IDX_DETECT_TWO_ENABLE = 5;
	localparam int IDX_PRECISE_TONE_DETECT_ENABLE = 11;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} grmb_state_e;
	typedef logic [RW_COUNT-1:0][7:0] grmb_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] mailbox_port_select;
		logic [7:0] wdata;
	} grmb_host_req_s;

	typedef struct packed {
		logic [7:0] connection_result;
		logic [7:0] tone_digit_detected;
		logic [7:0] detect_one_status;
		logic [7:0] detect_two_status;
		logic [7:0] precise_tone_detect_status;
		logic [15:0] error_magnitude;
	} grmb_status_s;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] data;
	} grmb_mbx_s;

endpackage : grmb_pkg

`default_nettype wire

// ---- logic/grmb_change_detect.sv ----
// Module: per-register change detector with sticky pending flag
`default_nettype none

module grmb_change_detect (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] status,
	input wire logic [7:0] enable,
	input wire logic clear,
	output logic pending
);

	typedef struct packed {
		logic [7:0] prev;
		logic pending;
	} grmb_det_s;

	grmb_det_s s;
	grmb_det_s next_s;
	logic change;

	always_comb begin
		next_s = s;
		change = |((status ^ s.prev) & enable);
		next_s.prev = status;
		// Set wins over clear
		next_s.pending = change | (s.pending & ~clear);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pending = s.pending;

	a_gate_enable: assert property (@(posedge ref_clk) disable iff (srst)
		(!s.pending && ((status ^ s.prev) & enable) == 8'h00) |=> !s.pending)
		else $error("Pending raised without an enabled change");

endmodule : grmb_change_detect

`default_nettype wire

// ---- logic/grmb_regfile.sv ----
// Module: general register storage and read selection
`default_nettype none

module grmb_regfile #(
	// Arbitrary revision code
	parameter logic [7:0] REVISION = 8'h5a
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire grmb_pkg::grmb_status_s status,
	output logic [7:0] rd_data,
	output logic writable,
	output logic readable,
	output grmb_pkg::grmb_ctrl_t ctrl
);

	typedef struct packed {
		grmb_pkg::grmb_ctrl_t rw;
	} grmb_rf_s;

	grmb_rf_s s;
	grmb_rf_s next_s;
	logic [3:0] idx;

	always_comb begin
		next_s = s;
		idx = 4'h0;
		writable = 1'b0;
		readable = 1'b1;
		rd_data = grmb_pkg::NULL_BYTE;
		for (int i = 0; i < grmb_pkg::RW_COUNT; i++) begin
			if (addr == grmb_pkg::RW_ADDRS[i]) begin
				idx = 4'(i);
				writable = 1'b1;
			end
		end
		case (addr)
			grmb_pkg::ADDR_CONNECTION_RESULT: rd_data = status.connection_result;
			grmb_pkg::ADDR_TONE_DIGIT_DETECTED: rd_data = status.tone_digit_detected;
			grmb_pkg::ADDR_SILICON_REVISION: rd_data = REVISION;
			grmb_pkg::ADDR_DETECT_ONE_STATUS: rd_data = status.detect_one_status;
			grmb_pkg::ADDR_DETECT_TWO_STATUS: rd_data = status.detect_two_status;
			grmb_pkg::ADDR_PRECISE_TONE_DETECT_STATUS: rd_data = status.precise_tone_detect_status;
			grmb_pkg::ADDR_ERROR_MAGNITUDE_LOW: rd_data = status.error_magnitude[7:0];
			grmb_pkg::ADDR_ERROR_MAGNITUDE_HIGH: rd_data = status.error_magnitude[15:8];
			default: readable = writable;
		endcase
		if (writable) begin
			rd_data = s.rw[idx];
		end
		if (wr_en && writable) begin
			next_s.rw[idx] = wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ctrl = s.rw;

endmodule : grmb_regfile

`default_nettype wire

// ---- tb/grmb_host_model.sv ----
// Host controller model that drives the mailbox port of the general register mailbox
`default_nettype none

module grmb_host_model (
	input wire logic ref_clk,
	input wire logic [7:0] host_rdata,
	input wire logic host_irq_n,
	output var grmb_pkg::grmb_host_req_s host_req
);
	timeunit 1ns;
	timeprecision 1ns;

	// Bytes are spaced out; the logic itself needs no gap, so the pace is compressed
	localparam int PACE_CYCLES = 2;

	initial begin
		host_req = '0;
	end

	// ****************************************
	// Byte transfers
	// ****************************************
	task automatic put(input logic [1:0] sel, input logic [7:0] val, input logic rd,
		output logic [7:0] got);
		repeat (PACE_CYCLES) @(negedge ref_clk);
		host_req.wr = !rd;
		host_req.rd = rd;
		host_req.mailbox_port_select = sel;
		host_req.wdata = rd ? 8'h00 : val;
		@(negedge ref_clk);
		host_req.wr = 1'b0;
		host_req.rd = 1'b0;
		// Idle bus never shows the last byte
		host_req.wdata = ~val;
		got = host_rdata;
	endtask : put

	task automatic wait_irq(output bit seen);
		int n;
		n = 0;
		while (host_irq_n !== 1'b0 && n < 10) begin
			@(negedge ref_clk);
			n++;
		end
		seen = (host_irq_n === 1'b0);
	endtask : wait_irq

	task automatic fetch(output logic [7:0] rc, output logic [7:0] rd);
		put(grmb_pkg::PORT_CTL, 8'h00, 1'b1, rc);
		put(grmb_pkg::PORT_DATA, 8'h00, 1'b1, rd);
	endtask : fetch

	task automatic xact(input logic [7:0] ctl, input logic [7:0] dat, output logic [7:0] rc,
		output logic [7:0] rd, output bit seen);
		logic [7:0] dummy;
		put(grmb_pkg::PORT_CTL, ctl, 1'b0, dummy);
		put(grmb_pkg::PORT_DATA, dat, 1'b0, dummy);
		wait_irq(seen);
		fetch(rc, rd);
	endtask : xact
endmodule : grmb_host_model

`default_nettype wire

// ---- tb/general_register_mailbox_bench.sv ----
// Self-checking bench for the general register mailbox
`default_nettype none

module general_register_mailbox_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// Arbitrary revision code
	localparam logic [7:0] REV = 8'hc3;
	logic ref_clk;
	logic srst;
	grmb_pkg::grmb_host_req_s host_req;
	grmb_pkg::grmb_status_s st;
	logic [7:0] host_rdata;
	logic host_irq_n;
	grmb_pkg::grmb_ctrl_t pump_ctrl;
	int error_cnt = 0;
	int tests_run = 0;
	int regs [32];
	int wr_list [12] = '{1, 3, 5, 6, 8, 10, 12, 13, 14, 16, 20, 24};
	int ro_list [8] = '{2, 4, 7, 9, 11, 17, 18, 25};
	int bad_list [5] = '{2, 0, 15, 19, 7};
	logic [7:0] lfsr = 8'h5f;
	logic [7:0] rc;
	logic [7:0] rd;
	bit seen;
	logic [15:0] rep_q [$];

	grmb_mailbox #(.REVISION(REV)) dut (
		.ref_clk(ref_clk),
		.srst(srst),
		.host_req(host_req),
		.host_rdata(host_rdata),
		.host_irq_n(host_irq_n),
		.pump_status(st),
		.pump_ctrl(pump_ctrl)
	);

	grmb_host_model host (
		.ref_clk(ref_clk),
		.host_rdata(host_rdata),
		.host_irq_n(host_irq_n),
		.host_req(host_req)
	);

	// ****************************************
	// Reference model and checking
	// ****************************************
	function logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction : rnd

	function logic [7:0] ro_val(input int a);
		case (a)
			2: return st.connection_result;
			4: return st.tone_digit_detected;
			7: return REV;
			9: return st.detect_one_status;
			11: return st.detect_two_status;
			17: return st.error_magnitude[7:0];
			18: return st.error_magnitude[15:8];
			25: return st.precise_tone_detect_status;
			default: return 8'h00;
		endcase
	endfunction : ro_val

	function logic [7:0] model(input logic [7:0] c, input logic [7:0] d);
		int a;
		a = int'(c[4:0]);
		if (c[5] && (c[7] || c[6])) return 8'h00;
		if (c[5]) return (a inside {wr_list}) ? 8'(regs[a]) : ro_val(a);
		if (c[7] || c[6] || a == 0 || !(a inside {wr_list})) return grmb_pkg::RESP_ERR;
		regs[a] = int'(d);
		return grmb_pkg::RESP_OK;
	endfunction : model

	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task cmd(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] e;
		host.xact(c, d, rc, rd, seen);
		e = model(c, d);
		chk({7'h0, seen}, 8'h01, "answer interrupt");
		chk(rc, c & 8'h7f, "echoed control");
		chk(rd, e, "answer data");
		chk({7'h0, host_irq_n}, 8'h01, "interrupt release");
	endtask : cmd

	task chk_report(input string what);
		logic [15:0] e;
		e = rep_q.pop_front();
		chk(rc, e[15:8], what);
		chk(rd, e[7:0], what);
	endtask : chk_report

	task report(input string what);
		host.wait_irq(seen);
		chk({7'h0, seen}, 8'h01, what);
		host.fetch(rc, rd);
		chk_report(what);
	endtask : report

	task stop_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	// ****************************************
	// Clock, watchdog and sequence
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	initial begin
		#1000000;
		error_cnt++;
		$display("unexpected at %0t: run did not finish", $time);
		stop_test();
	end

	initial begin
		srst = 1'b1;
		st = '0;
		st.connection_result = rnd();
		st.tone_digit_detected = rnd();
		st.error_magnitude = {rnd(), rnd()};
		repeat (3) @(negedge ref_clk);
		srst = 1'b0;
		chk({7'h0, host_irq_n}, 8'h01, "idle interrupt");
		host.put(grmb_pkg::PORT_CTL, 8'h00, 1'b1, rd);
		chk(rd, 8'h00, "empty control");
		host.put(grmb_pkg::PORT_DATA, 8'h00, 1'b1, rd);
		chk(rd, 8'h00, "empty data");
		foreach (wr_list[i]) cmd({3'h0, 5'(wr_list[i])}, rnd());
		foreach (wr_list[i]) begin
			chk(pump_ctrl[i], 8'(regs[wr_list[i]]), "control output");
			cmd({3'h1, 5'(wr_list[i])}, 8'h00);
		end
		foreach (ro_list[i]) cmd({3'h1, 5'(ro_list[i])}, 8'h00);
		foreach (bad_list[i]) cmd({3'h0, 5'(bad_list[i])}, rnd());
		cmd(8'h41, 8'h12);
		cmd(8'ha1, 8'h00);
		host.put(grmb_pkg::PORT_CTL, 8'h00, 1'b1, rd);
		chk(rd, 8'h00, "polled control after answer");
		// Only bit 0 of the first detect register may report
		cmd(8'h08, 8'h01);
		cmd(8'h0a, 8'h00);
		cmd(8'h18, 8'h00);
		st.detect_two_status = 8'hff;
		host.wait_irq(seen);
		chk({7'h0, seen}, 8'h00, "masked change");
		cmd(8'h22, 8'h00);
		st.detect_one_status = 8'h03;
		host.wait_irq(seen);
		chk({7'h0, seen}, 8'h01, "report interrupt");
		st.detect_one_status = 8'h02;
		host.fetch(rc, rd);
		chk(rc, 8'ha9, "report control");
		chk(rd, 8'h03, "report data");
		host.wait_irq(seen);
		chk({7'h0, seen}, 8'h01, "held report");
		host.fetch(rc, rd);
		chk(rc, 8'ha9, "held report control");
		chk(rd, 8'h02, "held report data");
		// Write direction, then a report from detector two, then detector one and the tone detector together
		cmd(8'h0a, 8'h80);
		st.detect_two_status = 8'h7f;
		rep_q.push_back({3'h4, grmb_pkg::ADDR_DETECT_TWO_STATUS, 8'h7f});
		report("second detector report");
		cmd(8'h18, 8'h01);
		st.precise_tone_detect_status = 8'h01;
		st.detect_one_status = 8'h03;
		rep_q.push_back({3'h4, grmb_pkg::ADDR_DETECT_ONE_STATUS, 8'h03});
		rep_q.push_back({3'h4, grmb_pkg::ADDR_PRECISE_TONE_DETECT_STATUS, 8'h01});
		report("first of two reports");
		report("queued tone report");
		// A command written under an unread report waits for the data read
		st.detect_one_status = 8'h02;
		rep_q.push_back({3'h4, grmb_pkg::ADDR_DETECT_ONE_STATUS, 8'h02});
		host.xact(8'h21, 8'h00, rc, rd, seen);
		chk_report("report ahead of command");
		host.wait_irq(seen);
		chk({7'h0, seen}, 8'h01, "held command interrupt");
		host.fetch(rc, rd);
		chk(rc, 8'h21, "held command echo");
		chk(rd, model(8'h21, 8'h00), "held command data");
		stop_test();
	end
endmodule : general_register_mailbox_bench

`default_nettype wire
